// ---- rtl/i2c_slave_defines.svh ----
// Constants for the two-wire register slave
`ifndef I2C_SLAVE_DEFINES_SVH
`define I2C_SLAVE_DEFINES_SVH
`define ADDR_BASE_SEL0      7'h44
`define ADDR_BASE_SEL1      7'h45
`define SOFT_RESET_OFFSET   8'h1F
`define POINTER_RESET       8'h00
`define REG_RESET_VALUE     8'h00
`define FILTER_LEN          3
`define MAX_BIT_RATE_KBPS   100
`endif

// ---- rtl/i2c_slave_pkg.sv ----
// Types for the two-wire register slave
package i2c_slave_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK
  } phase_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_type;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;
endpackage : i2c_slave_pkg

// ---- rtl/line_filter.sv ----
// Synchroniser and glitch filter for one bus line, following only when all LEN samples agree
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_defines.svh"
module line_filter #(
  parameter int LEN = `FILTER_LEN
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic           meta_r;
  logic           sync_r;
  logic [LEN-1:0] hist_r;

  initial
  begin
    if (LEN < 2 || LEN > 8)
      $error("line_filter: LEN out of range");
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end
    else
    begin
      meta_r <= line_i;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      hist_r <= '1;
    else
      hist_r <= {hist_r[LEN-2:0], sync_r};
  end

  // Output changes only once the line has been steady for LEN samples
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      line_o <= 1'b1;
    else if (&hist_r)
      line_o <= 1'b1;
    else if (~|hist_r)
      line_o <= 1'b0;
  end
endmodule : line_filter
`default_nettype wire

// ---- rtl/i2c_register_slave.sv ----
// Two-wire register slave reaching the control register file
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_defines.svh"
module i2c_register_slave #(
  parameter int NUM_REGS = 32
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic slave_address_select_pin_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  output logic      soft_reset_o,
  output logic      reg_we_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  ////////////////////////////////////////////////////////////////////////
  // Line conditioning and event detection

  i2c_slave_pkg::bus_lines_type   lines;
  i2c_slave_pkg::bus_lines_type   lines_d_r;
  i2c_slave_pkg::phase_type       phase_r;
  i2c_slave_pkg::reg_write_type   wr_r;
  logic                           sel_meta_r;
  logic                           sel_r;
  logic [7:0]                     regs_r [NUM_REGS];
  logic [7:0]                     shift_r;
  logic [2:0]                     bit_cnt_r;
  logic [7:0]                     pointer_r;
  logic                           first_byte_r;
  logic                           drive_low_r;
  logic                           byte_rx_r;
  logic                           scl_rise;
  logic                           scl_fall;
  logic                           start_det;
  logic                           stop_det;
  logic [7:0]                     read_byte;
  logic                           addr_match;
  logic                           read_fetch;

  initial
  begin
    if (NUM_REGS < 32 || NUM_REGS > 256)
      $error("i2c_register_slave: NUM_REGS out of range");
  end

  line_filter u_scl_filter (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .line_i  (scl_i),
    .line_o  (lines.scl)
  );

  line_filter u_sda_filter (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .line_i  (sda_i),
    .line_o  (lines.sda)
  );

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      lines_d_r <= '1;
    else
      lines_d_r <= lines;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sel_meta_r <= 1'b0;
      sel_r      <= 1'b0;
    end
    else
    begin
      sel_meta_r <= slave_address_select_pin_i;
      sel_r      <= sel_meta_r;
    end
  end

  assign scl_rise  = lines.scl & ~lines_d_r.scl;
  assign scl_fall  = ~lines.scl & lines_d_r.scl;
  // Data moves while clock high mark frame boundaries
  assign start_det = lines.scl & lines_d_r.scl & lines_d_r.sda
                     & ~lines.sda;
  assign stop_det  = lines.scl & lines_d_r.scl & ~lines_d_r.sda
                     & lines.sda;

  // Soft reset location has no storage and reads as zero
  assign read_byte = (pointer_r == `SOFT_RESET_OFFSET ||
                      {1'b0, pointer_r} >= 9'(NUM_REGS)) ? 8'h00
                     : regs_r[pointer_r[$clog2(NUM_REGS)-1:0]];

  assign addr_match = shift_r[7:1] == (sel_r ? `ADDR_BASE_SEL1
                                              : `ADDR_BASE_SEL0);

  // Each byte fetched for a read moves the pointer on
  assign read_fetch = scl_fall &&
                      (phase_r == i2c_slave_pkg::ST_READ_ACK ||
                       (phase_r == i2c_slave_pkg::ST_ADDR_ACK &&
                        shift_r[0]));

  ////////////////////////////////////////////////////////////////////////
  // Protocol sequencer

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      phase_r      <= i2c_slave_pkg::ST_IDLE;
      bit_cnt_r    <= 3'h0;
      shift_r      <= 8'h00;
      first_byte_r <= 1'b0;
    end
    else if (stop_det)
      phase_r <= i2c_slave_pkg::ST_IDLE;
    else if (start_det)
    begin
      phase_r   <= i2c_slave_pkg::ST_ADDR;
      bit_cnt_r <= 3'h0;
    end
    else
    begin
      unique case (phase_r)
        i2c_slave_pkg::ST_IDLE:
          bit_cnt_r <= 3'h0;
        i2c_slave_pkg::ST_ADDR, i2c_slave_pkg::ST_WRITE:
        begin
          if (scl_rise)
          begin
            shift_r   <= {shift_r[6:0], lines.sda};
            bit_cnt_r <= bit_cnt_r + 3'h1;
          end
          // Eighth bit done: acknowledge or drop the frame
          if (scl_fall && byte_rx_r)
          begin
            if (phase_r == i2c_slave_pkg::ST_WRITE)
              phase_r <= i2c_slave_pkg::ST_WRITE_ACK;
            else if (addr_match)
              phase_r <= i2c_slave_pkg::ST_ADDR_ACK;
            else
              phase_r <= i2c_slave_pkg::ST_IDLE;
          end
        end
        i2c_slave_pkg::ST_ADDR_ACK:
          if (scl_fall)
          begin
            first_byte_r <= 1'b1;
            if (shift_r[0])
            begin
              phase_r <= i2c_slave_pkg::ST_READ;
              shift_r <= read_byte;
            end
            else
              phase_r <= i2c_slave_pkg::ST_WRITE;
          end
        i2c_slave_pkg::ST_WRITE_ACK:
          if (scl_fall)
          begin
            first_byte_r <= 1'b0;
            phase_r      <= i2c_slave_pkg::ST_WRITE;
          end
        i2c_slave_pkg::ST_READ:
        begin
          if (scl_fall)
          begin
            shift_r   <= {shift_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7)
              phase_r <= i2c_slave_pkg::ST_READ_ACK;
          end
        end
        // Acknowledge sampled on the rise, next byte loaded on the fall
        i2c_slave_pkg::ST_READ_ACK:
          if (scl_rise && lines.sda)
            phase_r <= i2c_slave_pkg::ST_IDLE;
          else if (scl_fall)
          begin
            phase_r <= i2c_slave_pkg::ST_READ;
            shift_r <= read_byte;
          end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge and data drive, changed only after clock falls

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || stop_det || start_det)
      drive_low_r <= 1'b0;
    else if (scl_fall)
    begin
      unique case (phase_r)
        i2c_slave_pkg::ST_ADDR:
          drive_low_r <= byte_rx_r & addr_match;
        i2c_slave_pkg::ST_WRITE:
          drive_low_r <= byte_rx_r;
        i2c_slave_pkg::ST_ADDR_ACK:
          drive_low_r <= shift_r[0] & ~read_byte[7];
        i2c_slave_pkg::ST_READ:
          drive_low_r <= bit_cnt_r != 3'h7 & ~shift_r[6];
        i2c_slave_pkg::ST_READ_ACK:
          drive_low_r <= ~read_byte[7];
        i2c_slave_pkg::ST_WRITE_ACK,
        i2c_slave_pkg::ST_IDLE:
          drive_low_r <= 1'b0;
      endcase
    end
  end

  // Eighth clock rise of a byte seen; cleared as that bit ends
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || stop_det || start_det)
      byte_rx_r <= 1'b0;
    else if (scl_rise && bit_cnt_r == 3'h7 &&
             (phase_r == i2c_slave_pkg::ST_ADDR ||
              phase_r == i2c_slave_pkg::ST_WRITE))
      byte_rx_r <= 1'b1;
    else if (scl_fall)
      byte_rx_r <= 1'b0;
  end

  // Pin drive follows the decision taken just after clock falls
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      sda_o    <= 1'b0;
      sda_oe_o <= drive_low_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pointer, register file and soft reset

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      pointer_r <= `POINTER_RESET;
    else if (phase_r == i2c_slave_pkg::ST_WRITE_ACK && scl_fall)
      pointer_r <= first_byte_r ? shift_r : pointer_r + 8'h01;
    else if (read_fetch)
      pointer_r <= pointer_r + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      wr_r <= '0;
    else
    begin
      wr_r.we <= phase_r == i2c_slave_pkg::ST_WRITE_ACK && scl_fall
                 && !first_byte_r;
      // Subaddress byte leaves the write port untouched
      if (phase_r == i2c_slave_pkg::ST_WRITE_ACK && scl_fall &&
          !first_byte_r)
      begin
        wr_r.addr <= pointer_r;
        wr_r.data <= shift_r;
      end
    end
  end

  generate
    for (genvar i = 0; i < NUM_REGS; i++)
    begin : g_reg
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i ||
            (wr_r.we && wr_r.addr == `SOFT_RESET_OFFSET))
          regs_r[i] <= `REG_RESET_VALUE;
        else if (wr_r.we && wr_r.addr == 8'(i))
          regs_r[i] <= wr_r.data;
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      soft_reset_o <= 1'b0;
      reg_we_o     <= 1'b0;
      reg_addr_o   <= 8'h00;
      reg_wdata_o  <= 8'h00;
    end
    else
    begin
      soft_reset_o <= wr_r.we && wr_r.addr == `SOFT_RESET_OFFSET;
      reg_we_o     <= wr_r.we;
      reg_addr_o   <= wr_r.addr;
      reg_wdata_o  <= wr_r.data;
    end
  end
endmodule : i2c_register_slave
`default_nettype wire

// ---- sim/i2c_register_slave_chk.sv ----
// Port assertions for the two-wire register slave
`timescale 1ns/10ps
`default_nettype none
module i2c_register_slave_chk #(
  parameter int NUM_REGS = 32
) (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       slave_address_select_pin_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       soft_reset_o,
  input wire logic       reg_we_o,
  input wire logic [7:0] reg_addr_o,
  input wire logic [7:0] reg_wdata_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("data output not low");
  oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data enable moved with clock high");
  oe_hold_a: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8])
    else $error("data enable too short");
  we_pulse_a: assert property (reg_we_o |=> !reg_we_o [*8])
    else $error("write strobe not single");
  srst_pulse_a: assert property (soft_reset_o |=> !soft_reset_o [*8])
    else $error("soft reset not single");
  we_scl_low_a: assert property (reg_we_o |-> !scl_i)
    else $error("write strobe with clock high");
  addr_hold_a: assert property ($changed(reg_addr_o) |-> reg_we_o)
    else $error("write address moved without strobe");
  srst_scl_a: assert property (soft_reset_o |-> !scl_i)
    else $error("soft reset with clock high");
endmodule : i2c_register_slave_chk
bind i2c_register_slave i2c_register_slave_chk #(.NUM_REGS(NUM_REGS))
  i2c_register_slave_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .scl_i(scl_i), .sda_i(sda_i),
  .slave_address_select_pin_i(slave_address_select_pin_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .soft_reset_o(soft_reset_o),
  .reg_we_o(reg_we_o), .reg_addr_o(reg_addr_o),
  .reg_wdata_o(reg_wdata_o));
`default_nettype wire

// ---- sim/i2c_master_model.sv ----
// Two-wire bus master model
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
  input  wire logic clk_i,
  input  wire logic slave_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic sda_drv;
  // Pulled-up wire, low when either side pulls
  assign sda_o = sda_drv & ~slave_oe_i;
  initial
  begin
    scl_o = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tk
  // Data moves only in the low phase
  // 160 ns bit: long low phase gives the slave time to answer
  task automatic bit_x(input logic b, output logic s);
    scl_o <= 1'b0;
    tk(2);
    sda_drv <= b;
    tk(8);
    scl_o <= 1'b1;
    tk(3);
    s = sda_o;
    tk(3);
  endtask : bit_x
  // Start when st is 1, else stop
  task automatic cond(input logic st);
    scl_o <= 1'b0;
    tk(2);
    sda_drv <= st;
    tk(8);
    scl_o <= 1'b1;
    tk(3);
    sda_drv <= !st;
    tk(3);
  endtask : cond
  task automatic start_c;
    cond(1'b1);
  endtask : start_c
  task automatic stop_c;
    cond(1'b0);
  endtask : stop_c
  // MSB first; released line sampled for acknowledge
  task automatic wr_bits(input logic [7:0] d, input int n, output logic a);
    logic s;
    for (int i = 7; i > 7 - n; i--) bit_x(d[i], s);
    a = 1'b0;
    if (n == 8)
    begin
      bit_x(1'b1, s);
      a = !s;
    end
  endtask : wr_bits
  // Withheld acknowledge ends the read
  task automatic rd_byte(input logic ak, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(!ak, s);
  endtask : rd_byte
endmodule : i2c_master_model
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the two-wire register slave
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk_i, rst_n_i, sel, scl, sda, oe, srst, we, dout;
  logic [7:0]  waddr, wdata;
  logic [15:0] wq[$];
  int          fail_count, samples_checked, srst_seen;
  i2c_register_slave i2c_register_slave_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
    .slave_address_select_pin_i(sel), .sda_o(dout), .sda_oe_o(oe),
    .soft_reset_o(srst), .reg_we_o(we), .reg_addr_o(waddr),
    .reg_wdata_o(wdata));
  i2c_master_model m (.clk_i(clk_i), .slave_oe_i(oe), .scl_o(scl),
    .sda_o(sda));
  always @(posedge clk_i)
  begin
    if (we === 1'b1) wq.push_back({waddr, wdata});
    if (srst === 1'b1) srst_seen++;
  end
  task automatic chk8(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic wb(input logic [7:0] d, input logic e);
    logic a;
    m.wr_bits(d, 8, a);
    chk8("ack", {7'h00, e}, {7'h00, a});
  endtask : wb
  task automatic rb(input logic ak, input logic [7:0] e);
    logic [7:0] d;
    m.rd_byte(ak, d);
    chk8("rdata", e, d);
  endtask : rb
  task automatic wexp(input logic [7:0] a, d);
    logic [15:0] w;
    w = wq.size() ? wq.pop_front() : 16'hXXXX;
    chk8("waddr", a, w[15:8]);
    chk8("wdata", d, w[7:0]);
  endtask : wexp
  task automatic sc_write;
    m.start_c();
    wb(8'h88, 1'b1);
    wb(8'h0A, 1'b1);
    wb(8'h55, 1'b1);
    wb(8'h66, 1'b1);
    m.stop_c();
    chk8("writes", 8'h02, 8'(wq.size()));
    wexp(8'h0A, 8'h55);
    wexp(8'h0B, 8'h66);
  endtask : sc_write
  task automatic sc_read;
    m.start_c();
    wb(8'h88, 1'b1);
    wb(8'h0A, 1'b1);
    m.start_c();
    wb(8'h89, 1'b1);
    rb(1'b1, 8'h55);
    rb(1'b0, 8'h66);
    m.stop_c();
    m.start_c();
    wb(8'h89, 1'b1);
    rb(1'b0, 8'h00);
    m.stop_c();
  endtask : sc_read
  task automatic sc_addr;
    logic a;
    m.start_c();
    wb(8'h8A, 1'b0);
    m.stop_c();
    @(posedge clk_i) sel <= 1'b1;
    m.start_c();
    wb(8'h88, 1'b0);
    m.stop_c();
    m.start_c();
    wb(8'h8A, 1'b1);
    wb(8'h03, 1'b1);
    m.wr_bits(8'hFF, 4, a);
    m.stop_c();
    m.start_c();
    wb(8'h8B, 1'b1);
    rb(1'b0, 8'h00);
    m.stop_c();
    chk8("writes", 8'h00, 8'(wq.size()));
  endtask : sc_addr
  task automatic sc_srst;
    m.start_c();
    wb(8'h8A, 1'b1);
    wb(8'h1F, 1'b1);
    wb(8'hA5, 1'b1);
    m.start_c();
    wb(8'h8A, 1'b1);
    wb(8'h0A, 1'b1);
    m.start_c();
    wb(8'h8B, 1'b1);
    rb(1'b0, 8'h00);
    m.stop_c();
    chk8("resets", 8'h01, 8'(srst_seen));
  endtask : sc_srst
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    rst_n_i = 1'b0;
    sel = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    sc_write;
    sc_read;
    sc_addr;
    sc_srst;
    give_verdict;
  end
  initial
  begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    give_verdict;
  end
endmodule : tb
`default_nettype wire
